// ---- src/sis_init_sequencer.v ----
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "sis_defines.vh"
module sis_init_sequencer #(
  parameter NOP_CYCLES = `SIS_NOP_US * `SIS_CLK_MHZ,
  parameter PALL_CYCLES = `SIS_PALL_US * `SIS_CLK_MHZ,
  parameter MODE_CYCLES = `SIS_MODE_US * `SIS_CLK_MHZ,
  parameter CNT_W = 24
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Wishbone slave
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatIn,
  output reg [31:0] wbDatOut,
  output wire wbAck,
  // Device register port, four-phase handshake
  output reg devReq,
  output reg [31:0] devAddr,
  output reg [31:0] devData,
  input wire devAck,
  // Status
  output reg initDone
);
  localparam S_IDLE = 5'b00001;
  localparam S_REQ = 5'b00010;
  localparam S_REL = 5'b00100;
  localparam S_WAIT = 5'b01000;
  localparam S_DONE = 5'b10000;

  localparam [3:0] ST_CLKDIV = 4'h0;
  localparam [3:0] ST_RASCAS0 = 4'h1;
  localparam [3:0] ST_RASCAS1 = 4'h2;
  localparam [3:0] ST_NOP = 4'h3;
  localparam [3:0] ST_PALL = 4'h4;
  localparam [3:0] ST_FASTREF = 4'h5;
  localparam [3:0] ST_NORMREF = 4'h6;
  localparam [3:0] ST_MODECMD = 4'h7;
  localparam [3:0] ST_MODE0 = 4'h8;
  localparam [3:0] ST_MODE1 = 4'h9;
  localparam [3:0] ST_NORMAL = 4'hA;
  localparam [3:0] ST_BUFFER = 4'hB;
  localparam [3:0] ST_LAST = 4'hB;

  reg [31:0] config_reg;
  reg [31:0] refresh_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [3:0] step_reg;
  reg [3:0] step_next;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;
  reg ackMeta_reg;
  reg ackSync_reg;
  reg ack_reg;
  reg abortPend_reg;
  reg [31:0] stepAddr;
  reg [31:0] stepData;
  reg [CNT_W-1:0] stepWait;
  reg stepSkip;

  wire [4:0] modeShift;
  wire [31:0] modeWord;
  wire [31:0] modeOffset;
  wire [1:0] casLat;
  wire [1:0] rasLat;
  wire [2:0] burstCode;
  wire [31:0] rasCasValue;
  wire cs1Present;
  wire bus32;
  wire wbReq;
  wire wbWrite;
  wire startPulse;
  wire abortPulse;
  wire busy;

  sis_mode_shift shifter (
    .colBits(config_reg[`SIS_CFG_COL_MSB:`SIS_CFG_COL_LSB]),
    .bankBits(config_reg[`SIS_CFG_BANK_MSB:`SIS_CFG_BANK_LSB]),
    .rowFirst(config_reg[`SIS_CFG_ROWFIRST]),
    .bus32(config_reg[`SIS_CFG_BUS32]),
    .shift(modeShift)
  );

  assign casLat = config_reg[`SIS_CFG_CAS_MSB:`SIS_CFG_CAS_LSB];
  assign rasLat = config_reg[`SIS_CFG_RAS_MSB:`SIS_CFG_RAS_LSB];
  assign bus32 = config_reg[`SIS_CFG_BUS32];
  assign cs1Present = config_reg[`SIS_CFG_CS1];
  assign burstCode = bus32 ? 3'h0 : 3'h1;
  // Sequential burst, CAS latency in bits 5:4, taken from the same field as the delay register
  assign modeWord = {25'h0, 1'b0, casLat, 1'b0, burstCode};
  assign modeOffset = modeWord << modeShift;
  // Half-cycle bit left at zero so latency is always whole cycles
  assign rasCasValue = ({30'h0, casLat} << `SIS_RC_CAS_LSB)
    | ({30'h0, rasLat} << `SIS_RC_RAS_LSB);

  // Wishbone slave: one wait state, ack held for a single cycle
  assign wbReq = wbCyc & wbStb;
  assign wbAck = ack_reg;
  // Writes land on the edge at which the master sees ack, never earlier
  assign wbWrite = wbReq & wbWe & ack_reg;
  assign startPulse = wbWrite & (wbAdr == `SIS_WB_CTRL) & wbSel[0]
    & wbDatIn[`SIS_CTRL_START];
  assign abortPulse = wbWrite & (wbAdr == `SIS_WB_CTRL) & wbSel[0]
    & wbDatIn[`SIS_CTRL_ABORT];
  assign busy = ~state_reg[0] & ~state_reg[4];

  // The handshake answer comes from another domain
  always @(posedge clk) begin
    if (rst) begin
      ackMeta_reg <= 1'b0;
      ackSync_reg <= 1'b0;
    end else begin
      ackMeta_reg <= devAck;
      ackSync_reg <= ackMeta_reg;
    end
  end

  // Per-step access and the wait that follows it
  always @* begin
    stepAddr = `SIS_DEV_REG_BASE;
    stepData = 32'h0;
    stepWait = {CNT_W{1'b0}};
    stepSkip = 1'b0;
    case (step_reg)
      ST_CLKDIV: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_CLKDIV;
        stepData = {28'h0, config_reg[`SIS_CFG_DIV_MSB:`SIS_CFG_DIV_LSB]};
      end
      ST_RASCAS0: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_RASCAS0;
        stepData = rasCasValue;
      end
      ST_RASCAS1: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_RASCAS1;
        stepData = rasCasValue;
        stepSkip = ~cs1Present;
      end
      ST_NOP: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_DYNCTRL;
        stepData = `SIS_DC_NOP;
        stepWait = NOP_CYCLES[CNT_W-1:0];
      end
      ST_PALL: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_DYNCTRL;
        stepData = `SIS_DC_PALL;
      end
      ST_FASTREF: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_REFRESH;
        stepData = {16'h0, refresh_reg[`SIS_REF_FAST_MSB:`SIS_REF_FAST_LSB]};
        stepWait = PALL_CYCLES[CNT_W-1:0];
      end
      ST_NORMREF: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_REFRESH;
        stepData = {16'h0, refresh_reg[`SIS_REF_NORM_MSB:`SIS_REF_NORM_LSB]};
      end
      ST_MODECMD: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_DYNCTRL;
        stepData = `SIS_DC_MODE;
      end
      ST_MODE0: begin
        stepAddr = `SIS_DEV_CS0_BASE + modeOffset;
        stepData = 32'h0;
        stepWait = MODE_CYCLES[CNT_W-1:0];
      end
      ST_MODE1: begin
        stepAddr = `SIS_DEV_CS1_BASE + modeOffset;
        stepData = 32'h0;
        stepWait = MODE_CYCLES[CNT_W-1:0];
        stepSkip = ~cs1Present;
      end
      ST_NORMAL: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_DYNCTRL;
        stepData = `SIS_DC_NORMAL;
      end
      ST_BUFFER: begin
        stepAddr = `SIS_DEV_REG_BASE + `SIS_DEV_BUFFER;
        stepData = `SIS_BUF_ENABLE;
      end
      default: begin
        stepSkip = 1'b1;
      end
    endcase
  end

  // Sequencer
  always @* begin
    state_next = state_reg;
    step_next = step_reg;
    count_next = count_reg;
    case (state_reg)
      S_IDLE, S_DONE: begin
        if (startPulse) begin
          state_next = S_REQ;
          step_next = ST_CLKDIV;
        end
      end
      S_REQ: begin
        if (stepSkip) begin
          // Unpopulated chip select: move on without touching the device
          if (step_reg == ST_LAST) begin
            state_next = S_DONE;
          end else begin
            step_next = step_reg + 4'h1;
          end
        end else if (ackSync_reg) begin
          state_next = S_REL;
        end
      end
      S_REL: begin
        if (!ackSync_reg) begin
          count_next = stepWait;
          if (abortPend_reg) begin
            state_next = S_IDLE;
          end else if (stepWait != {CNT_W{1'b0}}) begin
            state_next = S_WAIT;
          end else if (step_reg == ST_LAST) begin
            state_next = S_DONE;
          end else begin
            state_next = S_REQ;
            step_next = step_reg + 4'h1;
          end
        end
      end
      S_WAIT: begin
        if (abortPend_reg) begin
          state_next = S_IDLE;
        end else if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          state_next = S_REQ;
          step_next = step_reg + 4'h1;
        end else begin
          count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      step_reg <= 4'h0;
      count_reg <= {CNT_W{1'b0}};
      devReq <= 1'b0;
      devAddr <= 32'h0;
      devData <= 32'h0;
      initDone <= 1'b0;
      abortPend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      count_reg <= count_next;
      // Request held until answered, so the address never moves under the device
      if (state_reg[1] && ackSync_reg) begin
        devReq <= 1'b0;
      end else if (state_reg[1] && !stepSkip && !devReq) begin
        devReq <= 1'b1;
        devAddr <= stepAddr;
        devData <= stepData;
      end
      initDone <= state_next[4];
      if (state_next[0] || state_next[4] || startPulse) begin
        abortPend_reg <= 1'b0;
      end else if (abortPulse) begin
        abortPend_reg <= 1'b1;
      end
    end
  end

  // Register writes and read-back
  always @(posedge clk) begin
    if (rst) begin
      config_reg <= `SIS_CFG_RESET;
      refresh_reg <= `SIS_REF_RESET;
      ack_reg <= 1'b0;
      wbDatOut <= 32'h0;
    end else begin
      ack_reg <= wbReq & ~ack_reg;
      // Geometry is frozen while the sequence runs
      if (wbWrite && !busy && wbAdr == `SIS_WB_CONFIG) begin
        if (wbSel[0]) config_reg[7:0] <= wbDatIn[7:0];
        if (wbSel[1]) config_reg[15:8] <= {wbDatIn[15:8]};
        if (wbSel[2]) config_reg[23:16] <= wbDatIn[23:16];
        if (wbSel[3]) config_reg[31:24] <= wbDatIn[31:24];
      end
      if (wbWrite && !busy && wbAdr == `SIS_WB_REFRESH) begin
        if (wbSel[0]) refresh_reg[7:0] <= wbDatIn[7:0];
        if (wbSel[1]) refresh_reg[15:8] <= wbDatIn[15:8];
        if (wbSel[2]) refresh_reg[23:16] <= wbDatIn[23:16];
        if (wbSel[3]) refresh_reg[31:24] <= wbDatIn[31:24];
      end
      if (wbReq && !wbWe && !ack_reg) begin
        case (wbAdr)
          `SIS_WB_CONFIG: wbDatOut <= config_reg;
          `SIS_WB_REFRESH: wbDatOut <= refresh_reg;
          `SIS_WB_STATUS: wbDatOut <= {16'h0, 3'h0, state_reg, step_reg,
            2'h0, initDone, busy};
          `SIS_WB_MODEADDR: wbDatOut <= `SIS_DEV_CS0_BASE + modeOffset;
          default: wbDatOut <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ---- src/sis_defines.vh ----
`ifndef SIS_DEFINES_VH
`define SIS_DEFINES_VH

// Wishbone register offsets of the sequencer itself
`define SIS_WB_CTRL 8'h00
`define SIS_WB_CONFIG 8'h04
`define SIS_WB_REFRESH 8'h08
`define SIS_WB_STATUS 8'h0C
`define SIS_WB_MODEADDR 8'h10

// Control register fields
`define SIS_CTRL_START 0
`define SIS_CTRL_ABORT 1

// Config register fields
`define SIS_CFG_COL_LSB 0
`define SIS_CFG_COL_MSB 3
`define SIS_CFG_BANK_LSB 4
`define SIS_CFG_BANK_MSB 5
`define SIS_CFG_ROWFIRST 8
`define SIS_CFG_BUS32 9
`define SIS_CFG_CS1 10
`define SIS_CFG_CAS_LSB 12
`define SIS_CFG_CAS_MSB 13
`define SIS_CFG_RAS_LSB 14
`define SIS_CFG_RAS_MSB 15
`define SIS_CFG_DIV_LSB 16
`define SIS_CFG_DIV_MSB 19
`define SIS_CFG_RESET 32'h0000_2209

// Refresh register fields and reset value
`define SIS_REF_FAST_LSB 0
`define SIS_REF_FAST_MSB 15
`define SIS_REF_NORM_LSB 16
`define SIS_REF_NORM_MSB 31
`define SIS_REF_RESET 32'h0030_0002

// Device register map, relative to the device register base, then the absolute chip select windows
`define SIS_DEV_REG_BASE 32'h4008_1000
`define SIS_DEV_CLKDIV 32'h0000_0000
`define SIS_DEV_BUFFER 32'h0000_0004
`define SIS_DEV_DYNCTRL 32'h0000_0020
`define SIS_DEV_REFRESH 32'h0000_0024
`define SIS_DEV_RASCAS0 32'h0000_0104
`define SIS_DEV_RASCAS1 32'h0000_0124
`define SIS_DEV_CS0_BASE 32'hA000_0000
`define SIS_DEV_CS1_BASE 32'hB000_0000

// Dynamic memory control fields
`define SIS_DC_CKE_BIT 0
`define SIS_DC_CLK_BIT 1
`define SIS_DC_INVCLK_BIT 4
`define SIS_DC_CMD_LSB 7
`define SIS_DC_CMD_MSB 8
`define SIS_DC_NOP 32'h0000_0183
`define SIS_DC_PALL 32'h0000_0103
`define SIS_DC_MODE 32'h0000_0083
`define SIS_DC_NORMAL 32'h0000_0000
`define SIS_BUF_ENABLE 32'h0000_0001

// RAS/CAS delay register fields
`define SIS_RC_RAS_LSB 0
`define SIS_RC_CAS_LSB 8
`define SIS_RC_HALF_BIT 7

// Timing
`define SIS_CLK_MHZ 50
`define SIS_NOP_US 200
`define SIS_PALL_US 10
`define SIS_MODE_US 1

`endif

// ---- src/sis_mode_shift.v ----
`timescale 1ns/1ps
module sis_mode_shift (
  // Geometry
  input wire [3:0] colBits,
  input wire [1:0] bankBits,
  input wire rowFirst,
  input wire bus32,
  // Result
  output wire [4:0] shift
);
  wire [4:0] bankPart;
  wire [4:0] busPart;

  assign bankPart = rowFirst ? {3'h0, bankBits} : 5'h00;
  assign busPart = bus32 ? 5'h02 : 5'h01;
  assign shift = {1'b0, colBits} + bankPart + busPart;
endmodule

// ---- test/sis_props.sv ----
`timescale 1ns/1ps
`include "sis_defines.vh"
module sis_props #(
  parameter NOP_CYCLES = 20,
  parameter MODE_CYCLES = 5
) (
  // Clock, reset and bus
  input wire clk,
  input wire rst,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatIn,
  input wire [31:0] wbDatOut,
  input wire wbAck,
  // Device port and status
  input wire devReq,
  input wire [31:0] devAddr,
  input wire [31:0] devData,
  input wire devAck,
  input wire initDone
);
  localparam logic [31:0] DC = `SIS_DEV_REG_BASE + `SIS_DEV_DYNCTRL;
  logic reqQ;
  logic [31:0] lastAddr, lastData, idle;
  wire rise = devReq && !reqQ;
  // Idle only gives a lower bound: the design also spends the ack sync cycles
  always @(posedge clk) begin
    if (rst) begin
      reqQ <= 1'b0;
      lastAddr <= 32'h0;
      lastData <= 32'h0;
      idle <= 32'h0;
    end else begin
      reqQ <= devReq;
      idle <= devReq ? 32'h0 : idle + 32'h1;
      if (rise) begin
        lastAddr <= devAddr;
        lastData <= devData;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence s_ack;
    ##1 wbAck ##1 !wbAck;
  endsequence
  a_ack_one_wait: assert property ($rose(wbCyc && wbStb) ##0 s_take |-> s_ack)
    else $error("bus ack not one pulse after one wait state");
  a_dev_stable: assert property (devReq && reqQ |-> $stable(devAddr) && $stable(devData))
    else $error("device request changed while pending");
  a_dev_holds: assert property (devReq && !devAck |=> devReq)
    else $error("device request dropped before answer");
  a_nop_wait: assert property (rise && lastAddr == DC && lastData == `SIS_DC_NOP |->
    idle >= NOP_CYCLES) else $error("NOP held too briefly");
  a_pall_refresh: assert property (rise && lastAddr == DC && lastData == `SIS_DC_PALL |->
    devAddr == `SIS_DEV_REG_BASE + `SIS_DEV_REFRESH) else $error("no fast refresh after precharge");
  a_mode_wait: assert property (rise && lastAddr[31:29] == 3'b101 |->
    idle >= MODE_CYCLES) else $error("mode write followed too soon");
  a_inv_clock: assert property (devReq && devAddr == DC |-> !devData[`SIS_DC_INVCLK_BIT])
    else $error("inverted clock bit set");
  a_buffer_last: assert property (rise && lastAddr == DC && lastData == `SIS_DC_NORMAL |->
    devData == `SIS_BUF_ENABLE ##1 devReq) else $error("buffer not enabled after normal");
endmodule
bind sis_init_sequencer sis_props #(.NOP_CYCLES(NOP_CYCLES), .MODE_CYCLES(MODE_CYCLES))
  sis_props_i (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
  .devReq(devReq), .devAddr(devAddr), .devData(devData), .devAck(devAck),
  .initDone(initDone));

// ---- test/sis_dev_model.sv ----
`timescale 1ns/1ps
`include "sis_defines.vh"
module sis_dev_model (
  // Clock, reset and answer delay
  input logic clk,
  input logic rst,
  input logic [1:0] lag,
  // Register port
  input logic devReq,
  input logic [31:0] devAddr,
  input logic [31:0] devData,
  output logic devAck,
  // Observed writes
  output logic seenStb,
  output logic [31:0] seenAddr,
  output logic [31:0] seenData,
  output logic seenMode
);
  logic [1:0] waitCnt;
  logic [31:0] dynCtrlReg;
  always @(posedge clk) begin
    seenStb <= 1'b0;
    if (rst) begin
      devAck <= 1'b0;
      waitCnt <= 2'h0;
      dynCtrlReg <= 32'h0;
    end else if (devReq && !devAck) begin
      waitCnt <= waitCnt + 2'h1;
      if (waitCnt >= lag) begin
        devAck <= 1'b1;
        waitCnt <= 2'h0;
        seenStb <= 1'b1;
        seenAddr <= devAddr;
        seenData <= devData;
        // Window write in MODE is a mode register set on address and bank pins
        seenMode <= devAddr[31:29] == 3'b101 && dynCtrlReg[8:7] == 2'b01;
        if (devAddr == `SIS_DEV_REG_BASE + `SIS_DEV_DYNCTRL) dynCtrlReg <= devData;
      end
    end else if (devAck && !devReq) begin
      devAck <= 1'b0;
    end
  end
endmodule

// ---- test/sis_init_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`include "sis_defines.vh"
module sis_init_sequencer_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatIn = 32'h0, seed = 32'h99A8A784;
  logic [1:0] lag = 2'h0;
  wire [31:0] wbDatOut, devAddr, devData, seenAddr, seenData;
  wire wbAck, devReq, devAck, initDone, seenStb, seenMode;
  logic [64:0] devQ[$];
  logic [31:0] rdQ[$];
  int n_fail = 0;
  int checks = 0;
  initial forever #10 clk = ~clk;
  sis_init_sequencer #(.NOP_CYCLES(20), .PALL_CYCLES(10), .MODE_CYCLES(5))
    sis_init_sequencer_i (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .devReq(devReq), .devAddr(devAddr), .devData(devData), .devAck(devAck),
    .initDone(initDone));
  sis_dev_model sis_dev_model_i (.clk(clk), .rst(rst), .lag(lag), .devReq(devReq),
    .devAddr(devAddr), .devData(devData), .devAck(devAck), .seenStb(seenStb),
    .seenAddr(seenAddr), .seenData(seenData), .seenMode(seenMode));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cmpDev(input logic [64:0] exp, input logic [64:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED device write expected %h seen %h", exp, got);
    end
  endtask
  task expire(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    conclude();
  endtask
  task wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatIn <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 20) expire("bus ack");
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] adr, input logic [31:0] exp);
    rdQ.push_back(exp);
    wbCycle(1'b0, adr, 32'h0);
  endtask
  task ex(input logic [31:0] a, input logic [31:0] d, input logic m);
    devQ.push_back({m, a, d});
  endtask
  // Watches results and matches them against the oldest note
  always @(posedge clk) begin
    if (wbAck === 1'b1 && !wbWe) cmpWord("read", rdQ.pop_front(), wbDatOut);
    if (seenStb === 1'b1) cmpDev(devQ.size() > 0 ? devQ.pop_front() : '1, {seenMode, seenAddr, seenData});
  end
  task runSeq(input logic [31:0] cfg, input logic [31:0] rf, input logic ab);
    logic [31:0] rb, rc, ma;
    int i;
    rb = `SIS_DEV_REG_BASE;
    lag <= 2'(xs());
    rc = {22'h0, cfg[13:12], 6'h00, cfg[15:14]};
    ma = {26'h0, cfg[13:12], 3'h0, !cfg[9]} << ({1'b0, cfg[3:0]} + (cfg[8] ? cfg[5:4] : 2'h0)
      + (cfg[9] ? 3'h2 : 3'h1));
    ex(rb + `SIS_DEV_CLKDIV, {28'h0, cfg[19:16]}, 1'b0);
    ex(rb + `SIS_DEV_RASCAS0, rc, 1'b0);
    if (cfg[10]) ex(rb + `SIS_DEV_RASCAS1, rc, 1'b0);
    ex(rb + `SIS_DEV_DYNCTRL, `SIS_DC_NOP, 1'b0);
    if (!ab) begin
      ex(rb + `SIS_DEV_DYNCTRL, `SIS_DC_PALL, 1'b0);
      ex(rb + `SIS_DEV_REFRESH, {16'h0, rf[15:0]}, 1'b0);
      ex(rb + `SIS_DEV_REFRESH, {16'h0, rf[31:16]}, 1'b0);
      ex(rb + `SIS_DEV_DYNCTRL, `SIS_DC_MODE, 1'b0);
      ex(`SIS_DEV_CS0_BASE + ma, 32'h0, 1'b1);
      if (cfg[10]) ex(`SIS_DEV_CS1_BASE + ma, 32'h0, 1'b1);
      ex(rb + `SIS_DEV_DYNCTRL, `SIS_DC_NORMAL, 1'b0);
      ex(rb + `SIS_DEV_BUFFER, `SIS_BUF_ENABLE, 1'b0);
    end
    wbCycle(1'b1, `SIS_WB_CONFIG, cfg);
    wbCycle(1'b1, `SIS_WB_REFRESH, rf);
    wbCycle(1'b1, `SIS_WB_CTRL, 32'h1);
    // Busy: geometry change and second start must both be dropped
    wbCycle(1'b1, `SIS_WB_CONFIG, ~cfg);
    wbCycle(1'b1, `SIS_WB_CTRL, 32'h1);
    if (ab) begin
      for (i = 0; i < 500 && devQ.size() > 0; i++) @(posedge clk);
      wbCycle(1'b1, `SIS_WB_CTRL, 32'h2);
    end
    for (i = 0; i < 3000 && !ab && initDone !== 1'b1; i++) @(posedge clk);
    if (i == 3000) expire("done");
    repeat (60) @(posedge clk);
    cmpWord("pending writes", 32'h0, devQ.size());
    cmpWord("done", {31'h0, !ab}, {31'h0, initDone});
    rd(`SIS_WB_CONFIG, cfg);
    rd(`SIS_WB_MODEADDR, `SIS_DEV_CS0_BASE + ma);
  endtask
  initial begin
    int k;
    logic [31:0] c;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`SIS_WB_CONFIG, `SIS_CFG_RESET);
    rd(`SIS_WB_REFRESH, `SIS_REF_RESET);
    rd(`SIS_WB_CTRL, 32'h0);
    wbCycle(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    runSeq(`SIS_CFG_RESET, `SIS_REF_RESET, 1'b0);
    $display("test 0 done");
    for (k = 1; k < 6; k++) begin
      c = (xs() & 32'h000F_F733) | 32'h0000_0008;
      if (k == 3) c = (c | 32'h0000_0500) & ~32'h0000_0200;
      runSeq(c, xs(), k == 2);
      $display("test %0d done", k);
    end
    conclude();
  end
endmodule
